// ==== bpe_port_ctrl.sv ====
// board port enable control register file
`timescale 1ns/1ns
`include "bpe_defines.svh"

// Overview of operation
// RQ1 - writing 1 to ethernet enable disables transceiver, 0 enables it
// RQ2 - writing 1 to infrared enable disables it, 0 enables it
// RQ3 - infrared rate range chosen on falling edge of infrared enable
// RQ4 - low range: outside holds tx low 200 ns before enable falls
// RQ5 - high range: outside holds tx high for same time before enable falls
// RQ6 - each serial transceiver enabled while its active-low bit is low
// RQ7 - negated serial enable puts transceiver in standby, receiver outputs released
// RQ8 - carrier detect, data set ready, clear to send held asserted; rts ignored
// RQ9 - writing 1 to card enable disables card input buffers, 0 enables
// RQ10 - speaker buffer high impedance while card enable is negated
// RQ11 - card strobe and data buffers driven only while card powered
// RQ12 - software reads voltage sense before selecting card supply
// RQ13 - software removes card power when a detect line goes high
// RQ14 - five registers, imaged through whole chip select region
// RQ15 - each register is a readable and writable 32-bit word; status register ignores writes, irq clear write clears bits
// RQ16 - only upper sixteen data lines carry register bits
// RQ17 - write updates outputs next edge; read returns last written values
module bpe_port_ctrl (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // register port
   input  wire logic [14:0] regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [31:0] regRdData,
   // card and infrared pins
   input  wire logic [1:0]  cardDetectN,
   input  wire logic [1:0]  cardVoltageSenseN,
   input  wire logic        infraredTx,
   // enables, card supply select, modem control and range
   output logic             ethernetXcvrEnableN,
   output logic             infraredXcvrEnableN,
   output logic             serialPortAXcvrEnableN,
   output logic             serialPortBXcvrEnableN,
   output logic             cardPortEnableN,
   output logic [1:0]       cardSupplySelect,
   output logic             speakerBufOeN,
   output logic             cardBufOeN,
   output logic             serialRxOeAN,
   output logic             serialRxOeBN,
   output logic [1:0]       serialModemCtlOut,
   output bpe_pkg::bpe_range_t infraredRange,
   // interrupt
   output logic             irq
);
   import bpe_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] ctrl;
      logic [2:0]  irqStat;
      logic [2:0]  irqEn;
      logic [31:0] rdData;
      logic [1:0]  cdMeta;
      logic [1:0]  cdSync;
      logic [1:0]  vsMeta;
      logic [1:0]  vsSync;
      logic        txMeta;
      logic        txSync;
      logic        cardIn;
      logic        txPrev;
      logic [7:0]  txStable;
      logic        cardBufOff;
      logic        range;
      logic        irq;
   } bpe_state_t;

   bpe_state_t st_q;
   bpe_state_t st_d;

   localparam logic [7:0] SetupCy = 8'(`BPE_IRD_SETUP_CY);

   function automatic logic [31:0] upper(input logic [15:0] v);
      return {v, 16'h0000}; // RQ16
   endfunction

   function automatic logic [2:0] reg_index(input logic [14:0] a);
      return a[4:2]; // RQ14
   endfunction

   logic [2:0]  idx;
   logic [2:0]  evt;
   logic        newIrd;
   logic        cardNow;
   logic [31:0] rd;

   always_comb begin
      st_d    = st_q;
      idx     = reg_index(regAddr); // RQ14
      newIrd  = st_q.ctrl[`BPE_BIT_IRD - 16];
      rd      = 32'h0000_0000;
      evt     = 3'h0;
      // synchronisers
      st_d.cdMeta = cardDetectN;
      st_d.cdSync = st_q.cdMeta;
      st_d.vsMeta = cardVoltageSenseN;
      st_d.vsSync = st_q.vsMeta;
      st_d.txMeta = infraredTx;
      st_d.txSync = st_q.txMeta;
      st_d.txPrev = st_q.txSync;
      // writes
      if (regWrite) begin // RQ15 RQ17
         case (idx)
            `BPE_IDX_CFG:    st_d.cfg = regWrData[31:16];
            `BPE_IDX_CTRL: begin
               st_d.ctrl = regWrData[31:16]; // RQ1 RQ2 RQ6 RQ9
               newIrd    = regWrData[`BPE_BIT_IRD];
            end
            `BPE_IDX_IRQ_EN: st_d.irqEn = regWrData[18:16];
            `BPE_IDX_IRQ_CLR: st_d.irqStat = st_q.irqStat & ~regWrData[18:16];
            default: ;
         endcase
      end
      // tx stability counter for the settled bit in status
      if (st_q.txSync != st_q.txPrev) begin
         st_d.txStable = 8'h00;
      end else if (st_q.txStable != SetupCy) begin
         st_d.txStable = st_q.txStable + 8'h01;
      end
      // infrared enable falling edge latches range
      if (st_q.ctrl[`BPE_BIT_IRD - 16] && !newIrd) begin // RQ3 RQ4 RQ5
         st_d.range = st_q.txSync;
         evt[`BPE_IRQ_RNG] = 1'b1;
      end
      // card presence events, channel enabled only
      cardNow     = (st_q.cdSync == 2'b00);
      st_d.cardIn = cardNow;
      if (!st_q.ctrl[`BPE_BIT_CARD - 16]) begin
         evt[`BPE_IRQ_INS] = cardNow && !st_q.cardIn;  // RQ12
         evt[`BPE_IRQ_REM] = !cardNow && st_q.cardIn;  // RQ13
      end
      st_d.irqStat = st_d.irqStat | evt; // set wins over clear
      // card buffers off unless channel on and powered
      st_d.cardBufOff = st_d.ctrl[`BPE_BIT_CARD - 16] ||
                        (st_d.ctrl[`BPE_BIT_VCC1 - 16:`BPE_BIT_VCC0 - 16] == 2'b00); // RQ11
      // reads
      case (idx)
         `BPE_IDX_CFG:    rd = upper(st_q.cfg);
         `BPE_IDX_CTRL:   rd = upper(st_q.ctrl); // RQ17
         `BPE_IDX_STATUS: rd = upper({9'h000, (st_q.txStable == SetupCy),
                                      st_q.txSync, st_q.range,
                                      st_q.vsSync, st_q.cdSync});
         `BPE_IDX_IRQ_EN: rd = upper({13'h0000, st_q.irqEn});
         `BPE_IDX_IRQ_CLR: rd = upper({13'h0000, st_q.irqStat});
         default:         rd = 32'h0000_0000;
      endcase
      st_d.rdData = regRead ? rd : 32'h0000_0000;
      st_d.irq    = |(st_d.irqStat & st_d.irqEn);
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_q      <= '0;
         st_q.ctrl <= `BPE_CTRL_RST;
         st_q.cfg  <= `BPE_CFG_RST;
         st_q.cdMeta <= 2'h3;
         st_q.cdSync <= 2'h3;
         st_q.cardBufOff <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign regRdData              = st_q.rdData;
   assign ethernetXcvrEnableN    = st_q.ctrl[`BPE_BIT_ETH - 16];  // RQ1
   assign infraredXcvrEnableN    = st_q.ctrl[`BPE_BIT_IRD - 16];  // RQ2
   assign serialPortAXcvrEnableN = st_q.ctrl[`BPE_BIT_SERA - 16]; // RQ6
   assign serialPortBXcvrEnableN = st_q.ctrl[`BPE_BIT_SERB - 16]; // RQ6
   assign serialRxOeAN           = st_q.ctrl[`BPE_BIT_SERA - 16]; // RQ7
   assign serialRxOeBN           = st_q.ctrl[`BPE_BIT_SERB - 16]; // RQ7
   assign serialModemCtlOut      = 2'h3;                          // RQ8
   assign cardPortEnableN        = st_q.ctrl[`BPE_BIT_CARD - 16]; // RQ9
   assign speakerBufOeN          = st_q.ctrl[`BPE_BIT_CARD - 16]; // RQ10
   assign cardBufOeN             = st_q.cardBufOff;               // RQ11
   assign cardSupplySelect       = st_q.ctrl[`BPE_BIT_VCC1 - 16:`BPE_BIT_VCC0 - 16];
   assign infraredRange          = bpe_range_t'(st_q.range);
   assign irq                    = st_q.irq;

   // ****************************************
   // checks
   // ****************************************
   eth_follows_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
      regWrite && regAddr[4:2] == `BPE_IDX_CTRL |=> ethernetXcvrEnableN == $past(regWrData[16]))
      else $error("ethernet enable did not follow write");
   ird_follows_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
      regWrite && regAddr[4:2] == `BPE_IDX_CTRL |=> infraredXcvrEnableN == $past(regWrData[17]))
      else $error("infrared enable did not follow write");
   range_capture_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
      $fell(infraredXcvrEnableN) |-> infraredRange == bpe_range_t'($past(st_q.txSync)))
      else $error("range not captured at enable fall");
   serial_standby_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
      serialRxOeAN == serialPortAXcvrEnableN && serialRxOeBN == serialPortBXcvrEnableN)
      else $error("serial receiver not released in standby");
   speaker_off_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
      cardPortEnableN |-> speakerBufOeN)
      else $error("speaker driven while card disabled");
   card_unpowered_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
      cardSupplySelect == 2'b00 |-> cardBufOeN)
      else $error("card buffers driven without power");
   read_back_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
      regRead && regAddr[4:2] == `BPE_IDX_CTRL && !regWrite
      |=> regRdData[31:16] == $past(st_q.ctrl))
      else $error("read did not return control value");
   low_half_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ16
      regAddr[4:2] != `BPE_IDX_STATUS ##1 1'b1 |-> regRdData[15:0] == 16'h0000)
      else $error("lower data half not zero");

   // ****************************************
   // checks on the enable, supply, buffer and modem control pins
   // ****************************************
   sera_follows_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
      regWrite && reg_index(regAddr) == `BPE_IDX_CTRL
      |=> serialPortAXcvrEnableN == $past(regWrData[`BPE_BIT_SERA]))
      else $error("serial port a enable did not follow write");

   serb_follows_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
      regWrite && reg_index(regAddr) == `BPE_IDX_CTRL
      |=> serialPortBXcvrEnableN == $past(regWrData[`BPE_BIT_SERB]))
      else $error("serial port b enable did not follow write");

   card_follows_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
      regWrite && reg_index(regAddr) == `BPE_IDX_CTRL
      |=> cardPortEnableN == $past(regWrData[`BPE_BIT_CARD]))
      else $error("card enable did not follow write");

   supply_follows_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
      regWrite && reg_index(regAddr) == `BPE_IDX_CTRL
      |=> cardSupplySelect == $past(regWrData[`BPE_BIT_VCC1:`BPE_BIT_VCC0]))
      else $error("card supply select did not follow write");

   enables_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
      !(regWrite && reg_index(regAddr) == `BPE_IDX_CTRL)
      |=> $stable(ethernetXcvrEnableN) && $stable(infraredXcvrEnableN) && $stable(cardPortEnableN))
      else $error("enable changed without a write");

   modem_ctl_on_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ8
      serialModemCtlOut == 2'b11)
      else $error("modem control lines not asserted");

   card_off_buf_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
      cardPortEnableN |-> cardBufOeN)
      else $error("card buffers driven while channel disabled");

   speaker_on_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
      !cardPortEnableN |-> !speakerBufOeN)
      else $error("speaker released while card enabled");

   card_powered_buf_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
      !cardPortEnableN && cardSupplySelect != 2'b00 |-> !cardBufOeN)
      else $error("card buffers off while powered");

   // ****************************************
   // checks on the register port
   // ****************************************
   idle_read_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
      !regRead |=> regRdData == 32'h0000_0000)
      else $error("read data not zero outside a read");

   unmapped_read_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ14
      regRead && reg_index(regAddr) >= `BPE_NUM_REGS |=> regRdData == 32'h0000_0000)
      else $error("unmapped read not zero");

   unmapped_write_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ14
      regWrite && reg_index(regAddr) >= `BPE_NUM_REGS
      |=> $stable(cardSupplySelect) && $stable(ethernetXcvrEnableN))
      else $error("unmapped write changed control");

   // ****************************************
   // checks on range and interrupts
   // ****************************************
   range_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
      !$fell(infraredXcvrEnableN) |-> $stable(infraredRange))
      else $error("range changed without enable fall");

   range_event_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
      $fell(infraredXcvrEnableN) |-> st_q.irqStat[`BPE_IRQ_RNG])
      else $error("range event not recorded");

   insert_event_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
      !cardPortEnableN && st_q.cdSync == 2'b00 && !st_q.cardIn
      |=> st_q.irqStat[`BPE_IRQ_INS])
      else $error("card insertion not recorded");

   remove_event_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
      !cardPortEnableN && st_q.cdSync != 2'b00 && st_q.cardIn
      |=> st_q.irqStat[`BPE_IRQ_REM])
      else $error("card removal not recorded");

   irq_masked_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
      regWrite && reg_index(regAddr) == `BPE_IDX_IRQ_EN && regWrData[18:16] == 3'h0
      |=> !irq)
      else $error("interrupt raised while all masked");
endmodule // bpe_port_ctrl

// ==== bpe_defines.svh ====
// register offsets, field positions and reset values of the board control file
`ifndef BPE_DEFINES_SVH
`define BPE_DEFINES_SVH
// word index of each of the five registers
`define BPE_IDX_CFG      3'h0
`define BPE_IDX_CTRL     3'h1
`define BPE_IDX_STATUS   3'h2
`define BPE_IDX_IRQ_EN   3'h3
`define BPE_IDX_IRQ_CLR  3'h4
`define BPE_NUM_REGS     3'h5
// control register fields, in upper data half
`define BPE_BIT_ETH      16
`define BPE_BIT_IRD      17
`define BPE_BIT_SERA     18
`define BPE_BIT_SERB     19
`define BPE_BIT_CARD     20
`define BPE_BIT_VCC0     21
`define BPE_BIT_VCC1     22
// status fields
`define BPE_ST_CD_LO     16
`define BPE_ST_VS_LO     18
`define BPE_ST_RANGE     20
`define BPE_ST_TX        21
// interrupt bits: card inserted, card removed, range latched
`define BPE_IRQ_INS      0
`define BPE_IRQ_REM      1
`define BPE_IRQ_RNG      2
// reset values: ports disabled, card power off
`define BPE_CTRL_RST     16'h001F
`define BPE_CFG_RST      16'h0000
// tx settle time before infrared enable falls
`define BPE_IRD_SETUP_NS 200
`define BPE_CLK_NS       10
`define BPE_IRD_SETUP_CY ((`BPE_IRD_SETUP_NS + `BPE_CLK_NS - 1) / `BPE_CLK_NS)
`endif

// ==== bpe_pkg.sv ====
// types of the board port enable control block
package bpe_pkg;
   typedef enum logic {
      BPE_RANGE_LOW,
      BPE_RANGE_HIGH
   } bpe_range_t;
endpackage

// ==== bpe_host_model.sv ====
// host processor model driving the register port and infrared tx pin
`timescale 1ns/1ns
module bpe_host_model (
   // clock
   input  wire logic        clock,
   // register port
   output logic      [14:0] regAddr,
   output logic      [31:0] regWrData,
   output logic             regWrite,
   output logic             regRead,
   input  wire logic [31:0] regRdData,
   // infrared pin
   output logic             infraredTx
);
   // *****
   // bus cycles
   // *****
   initial begin
      regAddr = 15'h0000;
      regWrData = 32'h00000000;
      regWrite = 1'b0;
      regRead = 1'b0;
      infraredTx = 1'b0;
   end
   task automatic wr(input logic [14:0] a, input logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [14:0] a, output logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      d = regRdData;
   endtask
   // tx settles before infrared enable falls
   task automatic ird_fall(input logic tx);
      @(posedge clock);
      infraredTx <= tx;
      repeat (25) @(posedge clock);
      wr(15'h0004, 32'h001D0000);
   endtask
endmodule // bpe_host_model

// ==== board_port_enable_control_tb.sv ====
// self-checking bench of the board port enable control block
`timescale 1ns/1ns
module board_port_enable_control_tb;
   import bpe_pkg::*;
   logic clock, rst_n, regWrite, regRead, infraredTx, irq;
   logic [14:0] regAddr;
   logic [31:0] regWrData, regRdData, d, r;
   logic [1:0] cardDetectN, cardVoltageSenseN;
   logic [12:0] pins;
   bpe_range_t infraredRange;
   int errTotal, comparisons, seed, i, k;
   // *****
   // design and host
   // *****
   bpe_port_ctrl bpe_port_ctrl_i (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .cardDetectN(cardDetectN), .cardVoltageSenseN(cardVoltageSenseN),
      .infraredTx(infraredTx), .ethernetXcvrEnableN(pins[2]), .infraredXcvrEnableN(pins[3]),
      .serialPortAXcvrEnableN(pins[4]), .serialPortBXcvrEnableN(pins[5]),
      .cardPortEnableN(pins[6]), .cardSupplySelect(pins[8:7]), .speakerBufOeN(pins[9]),
      .cardBufOeN(pins[10]), .serialRxOeAN(pins[11]), .serialRxOeBN(pins[12]),
      .serialModemCtlOut(pins[1:0]), .infraredRange(infraredRange), .irq(irq));
   bpe_host_model bpe_host_model_i (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .infraredTx(infraredTx));
   // expected pins from control bits
   function automatic logic [12:0] expect_pins(input logic [6:0] c);
      return {c[3], c[2], ~(~c[4] & |c[6:5]), c[4], c[6:5], c[4:0], 2'b11};
   endfunction
   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #200000;
      errTotal++;
      stop_test();
   end
   // *****
   // tests
   // *****
   initial begin
      errTotal = 0;
      comparisons = 0;
      seed = 99;
      rst_n = 1'b0;
      cardDetectN = 2'b11;
      cardVoltageSenseN = 2'b10;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      bpe_host_model_i.rd(15'h0004, d);
      chk("ctrl", d, 32'h001F0000);
      chk("pins", pins, expect_pins(7'h1F));
      $display("reset test done");
      for (i = 0; i < 40; i++) begin
         r = (i < 2) ? {32{i[0]}} : $random(seed);
         bpe_host_model_i.wr({r[14:5], 3'h1, r[1:0]}, r);
         chk("pins", pins, expect_pins(r[22:16]));
         bpe_host_model_i.rd({~r[14:5], 5'h04}, d);
         chk("ctrl", d, {r[31:16], 16'h0000});
      end
      bpe_host_model_i.wr(15'h0014, 32'hFFFFFFFF);
      bpe_host_model_i.rd(15'h0014, d);
      chk("unmapped", d, 32'h00000000);
      chk("pins", pins, expect_pins(r[22:16]));
      bpe_host_model_i.rd(15'h0008, d);
      chk("sense", {28'h0, d[19:16]}, 32'h0000000B);
      $display("register test done");
      bpe_host_model_i.wr(15'h0010, 32'hFFFF0000);
      bpe_host_model_i.wr(15'h000C, 32'h00040000);
      for (i = 1; i >= 0; i--) begin
         bpe_host_model_i.wr(15'h0004, 32'h001F0000);
         bpe_host_model_i.ird_fall(i[0]);
         for (k = 0; k < 10 && irq !== 1'b1; k++) @(posedge clock);
         #1;
         chk("range", {31'h0, infraredRange}, {31'h0, i[0]});
         chk("irq", {31'h0, irq}, 32'h1);
         bpe_host_model_i.wr(15'h000C, 32'h00000000);
         chk("irq", {31'h0, irq}, 32'h0);
         bpe_host_model_i.wr(15'h0010, 32'h00040000);
         bpe_host_model_i.wr(15'h000C, 32'h00040000);
         chk("irq", {31'h0, irq}, 32'h0);
      end
      $display("infrared test done");
      bpe_host_model_i.wr(15'h0010, 32'hFFFF0000);
      bpe_host_model_i.wr(15'h000C, 32'h00030000);
      bpe_host_model_i.wr(15'h0004, 32'h000F0000);
      cardDetectN <= 2'b00;
      repeat (6) @(posedge clock);
      #1;
      chk("irq", {31'h0, irq}, 32'h1);
      bpe_host_model_i.rd(15'h0010, d);
      chk("istat", d, 32'h00010000);
      bpe_host_model_i.rd(15'h0008, d);
      chk("sense", {28'h0, d[19:16]}, 32'h00000008);
      bpe_host_model_i.wr(15'h0004, 32'h002F0000);
      chk("pins", pins, expect_pins(7'h2F));
      cardDetectN <= 2'b01;
      repeat (6) @(posedge clock);
      bpe_host_model_i.rd(15'h0010, d);
      chk("istat", d, 32'h00030000);
      bpe_host_model_i.wr(15'h0004, 32'h000F0000);
      chk("pins", pins, expect_pins(7'h0F));
      $display("card test done");
      stop_test();
   end
endmodule // board_port_enable_control_tb
